// [bench/dac_cal_checker.sv]
`timescale 1ns/1ps
module dac_cal_checker
    import dac_cal_pkg::*;
#(
    parameter int CAL_TICKS_P = CAL_TICKS
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic spiSclk,
    input wire logic spiCsN,
    input wire logic spiSdo,
    input wire logic spiSdoOeN,
    input wire logic [CODE_W-1:0] iFineGainCode,
    input wire logic [CODE_W-1:0] qFineGainCode,
    input wire logic [CODE_W-1:0] iCoarseGainCode,
    input wire logic [CODE_W-1:0] qCoarseGainCode,
    input wire logic [CODE_W-1:0] iCmResistorCode,
    input wire logic [CODE_W-1:0] qCmResistorCode,
    input wire logic iCmResistorEnable,
    input wire logic qCmResistorEnable,
    input wire logic [CODE_W-1:0] referenceTrimCode,
    input wire logic iUncalMode,
    input wire logic qUncalMode
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    // gain and resistor codes only move on a committed write
    logic [6*CODE_W-1:0] gainCodes;
    assign gainCodes = {iFineGainCode, qFineGainCode, iCoarseGainCode, qCoarseGainCode,
        iCmResistorCode, qCmResistorCode};

    a_reset_clears_codes: assert property ($rose(resetn) |-> gainCodes == '0 &&
        !iCmResistorEnable && !qCmResistorEnable && referenceTrimCode == '0 && spiSdoOeN)
        else $error("codes not cleared by reset");
    a_oen_idle_high: assert property (spiCsN [*3] |-> spiSdoOeN)
        else $error("data out enabled outside a frame");
    a_oen_fall_frame: assert property ($fell(spiSdoOeN) |-> !spiCsN && !spiSclk)
        else $error("data out enabled away from a clock fall");
    a_oen_holds_low: assert property ($fell(spiSdoOeN) |-> !spiSdoOeN [*2])
        else $error("data out enable glitched");
    a_sdo_quiet: assert property (spiCsN [*3] |-> $stable(spiSdo))
        else $error("data out moved while deselected");
    a_trim_quiet: assert property (spiCsN && $past(spiCsN) |-> $stable(referenceTrimCode))
        else $error("reference trim moved while deselected");
    a_gain_commit_edge: assert property ($changed(gainCodes) |->
        !spiCsN && spiSclk && $past(spiSclk)) else $error("gain code moved off a commit");
    a_uncal_frame: assert property ($changed({iUncalMode, qUncalMode}) |->
        $past(spiCsN) == 1'b0) else $error("uncal mode moved outside a frame");
endmodule // dac_cal_checker

bind dac_selfcal_gain_trim_control dac_cal_checker #(.CAL_TICKS_P(CAL_TICKS_P)) chk (
    .mclk(mclk), .resetn(resetn), .spiSclk(spiSclk), .spiCsN(spiCsN), .spiSdo(spiSdo),
    .spiSdoOeN(spiSdoOeN), .iFineGainCode(iFineGainCode), .qFineGainCode(qFineGainCode),
    .iCoarseGainCode(iCoarseGainCode), .qCoarseGainCode(qCoarseGainCode),
    .iCmResistorCode(iCmResistorCode), .qCmResistorCode(qCmResistorCode),
    .iCmResistorEnable(iCmResistorEnable), .qCmResistorEnable(qCmResistorEnable),
    .referenceTrimCode(referenceTrimCode), .iUncalMode(iUncalMode), .qUncalMode(qUncalMode));

// [bench/dac_selfcal_gain_trim_control_tb.sv]
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin failures++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module dac_selfcal_gain_trim_control_tb;
    import dac_cal_pkg::*;
    localparam int CAL_N = 4;
    logic mclk = 0, resetn = 0, spiSclk = 0, spiCsN = 1, spiSdi = 0, spiSdo, spiSdoOeN;
    logic [COEF_W-1:0] iCalMeasure = 0, qCalMeasure = 0, iConvCoef, qConvCoef;
    logic [COEF_IDX_W-1:0] convCoefIndex = 0;
    logic [CODE_W-1:0] iFineGainCode, qFineGainCode, iCoarseGainCode, qCoarseGainCode;
    logic [CODE_W-1:0] iCmResistorCode, qCmResistorCode, referenceTrimCode;
    logic iCmResistorEnable, qCmResistorEnable, iUncalMode, qUncalMode;
    int failures = 0, comparisons = 0;
    logic [7:0] mreg [0:31];
    logic [5:0] cmem [0:1][0:31];
    logic [1:0] mdone = 2'b00;
    logic [7:0] v;
    logic [4:0] trims [0:6] = '{5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h0D};

    dac_selfcal_gain_trim_control #(.CAL_TICKS_P(CAL_N)) DUT (.mclk, .resetn, .spiSclk,
        .spiCsN, .spiSdi, .spiSdo, .spiSdoOeN, .iCalMeasure, .qCalMeasure, .convCoefIndex,
        .iConvCoef, .qConvCoef, .iFineGainCode, .qFineGainCode, .iCoarseGainCode,
        .qCoarseGainCode, .iCmResistorCode, .qCmResistorCode, .iCmResistorEnable,
        .qCmResistorEnable, .referenceTrimCode, .iUncalMode, .qUncalMode);

    initial begin
        forever #5 mclk = ~mclk;
    end

    // ------------------------------------------------------------
    // serial frame and model
    // ------------------------------------------------------------
    // slow serial clock keeps every phase at least two sample clocks
    task automatic spi(input logic [7:0] ins, input logic [7:0] din, output logic [7:0] dout);
        logic [15:0] w;
        w = {ins, din};
        dout = 8'h00;
        @(posedge mclk) spiCsN <= 1'b0;
        for (int i = 15; i >= 0; i--) begin
            @(posedge mclk) spiSclk <= 1'b0;
            spiSdi <= w[i];
            repeat (3) @(posedge mclk);
            if (i < 8) dout[i] = spiSdo;
            spiSclk <= 1'b1;
            repeat (2) @(posedge mclk);
        end
        spiSclk <= 1'b0;
        repeat (2) @(posedge mclk);
        spiCsN <= 1'b1;
        repeat (2) @(posedge mclk);
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        int ca;
        spi({3'b000, a}, d, v);
        ca = mreg[OFS_COEF_ADDRESS];
        if (a == OFS_COEF_DATA && mreg[OFS_CAL_CONTROL][3] && ca >= 1 && ca <= 32) begin
            for (int c = 0; c < 2; c++) begin
                if (mreg[OFS_CAL_SETUP][4+c]) cmem[c][ca-1] = d[5:0];
            end
        end
        if (a inside {[5'h03:5'h08], [5'h0D:5'h0E], [5'h10:5'h12]}) mreg[a] = d;
    endtask

    // coefficient view only with the read strobe and exactly one core
    function automatic logic [7:0] mread(input logic [4:0] a);
        logic [1:0] s;
        int ca;
        s = mreg[OFS_CAL_SETUP][5:4];
        ca = mreg[OFS_COEF_ADDRESS];
        if (a == OFS_CAL_STATUS) return {mdone, 6'h00};
        if (a == OFS_COEF_DATA && mreg[OFS_CAL_CONTROL][2] && (s == 2'b01 || s == 2'b10)
            && ca >= 1 && ca <= 32) return {2'b00, cmem[s[1]][ca-1]};
        return mreg[a];
    endfunction

    task automatic rd_chk(input logic [4:0] a);
        spi({3'b100, a}, 8'h00, v);
        `CHK($sformatf("register %h", a), mread(a), v)
    endtask

    task automatic chk_out();
        `CHK("code outputs", {mreg[3][5:0], mreg[6][5:0], mreg[4][5:0], mreg[7][5:0],
            mreg[5][5:0], mreg[8][5:0], mreg[5][7], mreg[8][7], mreg[13][5:0], mreg[18][1:0]},
            {iFineGainCode, qFineGainCode, iCoarseGainCode, qCoarseGainCode, iCmResistorCode,
            qCmResistorCode, iCmResistorEnable, qCmResistorEnable, referenceTrimCode,
            iUncalMode, qUncalMode})
    endtask

    task automatic read_coef(input int a);
        wr(OFS_COEF_ADDRESS, 8'(a));
        wr(OFS_CAL_CONTROL, 8'h04);
        rd_chk(OFS_COEF_DATA);
        wr(OFS_CAL_CONTROL, 8'h00);
    endtask

    task automatic end_test(input string nm);
        $display("test %s finished, failures %0d", nm, failures);
    endtask

    task automatic stop_test();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        void'($urandom(5891));
        foreach (mreg[a]) mreg[a] = 8'h00;
        foreach (cmem[c, a]) cmem[c][a] = 6'h00;
        repeat (5) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        chk_out();
        for (int a = 0; a < 32; a++) rd_chk(5'(a));
        end_test("reset values");
        foreach (trims[k]) begin
            wr(trims[k], 8'($urandom));
            rd_chk(trims[k]);
            chk_out();
        end
        wr(OFS_CAL_STATUS, 8'hFF);
        rd_chk(OFS_CAL_STATUS);
        wr(5'h1F, 8'hA5);
        rd_chk(5'h1F);
        end_test("trim registers");
        for (int c = 0; c < 2; c++) begin
            wr(OFS_CAL_SETUP, c ? 8'h20 : 8'h10);
            wr(OFS_CAL_CONTROL, 8'h08);
            for (int a = 1; a <= 32; a++) begin
                wr(OFS_COEF_ADDRESS, 8'(a));
                wr(OFS_COEF_DATA, 8'($urandom));
            end
            wr(OFS_CAL_CONTROL, 8'h00);
            wr(OFS_CAL_SETUP, 8'h00);
        end
        // stray stores: no core selected, then address zero
        wr(OFS_CAL_CONTROL, 8'h08);
        wr(OFS_COEF_ADDRESS, 8'h05);
        wr(OFS_COEF_DATA, 8'h2A);
        wr(OFS_CAL_SETUP, 8'h10);
        wr(OFS_COEF_ADDRESS, 8'h00);
        wr(OFS_COEF_DATA, 8'h15);
        wr(OFS_CAL_CONTROL, 8'h00);
        repeat (8) begin
            @(posedge mclk) convCoefIndex <= 5'($urandom);
            repeat (2) @(posedge mclk);
            `CHK("i conv coef", cmem[0][convCoefIndex], iConvCoef)
            `CHK("q conv coef", cmem[1][convCoefIndex], qConvCoef)
        end
        end_test("coefficient write");
        for (int c = 0; c < 2; c++) begin
            wr(OFS_CAL_SETUP, c ? 8'h20 : 8'h10);
            for (int a = 1; a <= 32; a++) read_coef(a);
        end
        wr(OFS_CAL_SETUP, 8'h30);
        read_coef(5);
        wr(OFS_CAL_SETUP, 8'h00);
        end_test("coefficient read");
        iCalMeasure <= 6'($urandom);
        qCalMeasure <= 6'($urandom);
        wr(OFS_CAL_CONTROL, 8'h03);
        chk_out();
        wr(OFS_CAL_CONTROL, 8'h00);
        chk_out();
        wr(OFS_CAL_SETUP, 8'h38);
        wr(OFS_CAL_CONTROL, 8'h10);
        // four ticks of 32 clocks: still running at this poll, done by the third
        rd_chk(OFS_CAL_STATUS);
        for (int n = 0; n < 2 && v !== 8'hC0; n++) spi({3'b100, OFS_CAL_STATUS}, 8'h00, v);
        mdone = 2'b11;
        for (int k = 0; k < CAL_N && k < 32; k++) begin
            cmem[0][k] = iCalMeasure;
            cmem[1][k] = qCalMeasure;
        end
        rd_chk(OFS_CAL_STATUS);
        wr(OFS_CAL_CONTROL, 8'h00);
        wr(OFS_CAL_SETUP, 8'h08);
        wr(OFS_CAL_SETUP, 8'h00);
        rd_chk(OFS_CAL_STATUS);
        for (int c = 0; c < 2; c++) begin
            wr(OFS_CAL_SETUP, c ? 8'h20 : 8'h10);
            for (int a = 1; a <= 6; a++) read_coef(a);
        end
        end_test("self calibration");
        stop_test();
    end

    // hang guard, well beyond the expected run length
    initial begin
        repeat (90000) @(posedge mclk);
        failures++;
        stop_test();
    end
endmodule // dac_selfcal_gain_trim_control_tb

// [logic/cal_core.sv]
`timescale 1ns/1ps
module cal_core
    import dac_cal_pkg::*;
#(
    parameter int CAL_TICKS_P = CAL_TICKS
) (
    input wire logic mclk,
    input wire logic resetn,
    cal_core_if.core bus
);

    // ------------------------------------------------------------
    // coefficient store and sequencer
    // ------------------------------------------------------------
    logic [COEF_W-1:0] coefMem [COEF_COUNT];
    cal_state_t state_reg, state_next;
    logic [8:0] tickCnt_reg;
    logic done_reg;
    logic [COEF_W-1:0] convData_reg;

    wire logic finishing = (state_reg == CAL_RUN) && bus.tick
        && (tickCnt_reg == 9'(CAL_TICKS_P - 1));
    wire logic storeStep = (state_reg == CAL_RUN) && bus.tick
        && (tickCnt_reg < 9'(COEF_COUNT));
    wire logic [COEF_IDX_W-1:0] stepIdx = tickCnt_reg[COEF_IDX_W-1:0];

    // next state; a start held high after finish waits for the host clear
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            CAL_IDLE: if (bus.start) state_next = CAL_RUN;
            CAL_RUN: begin
                if (!bus.start) state_next = CAL_IDLE;
                else if (finishing) state_next = CAL_FINISH;
            end
            CAL_FINISH: if (!bus.start) state_next = CAL_IDLE;
            default: state_next = CAL_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            state_reg <= CAL_IDLE;
            tickCnt_reg <= '0;
        end else begin
            state_reg <= state_next;
            if (state_reg != CAL_RUN) tickCnt_reg <= '0;
            else if (bus.tick) tickCnt_reg <= tickCnt_reg + 9'h001;
        end
    end

    // sticky done; a new start clears it but a finish in the same cycle wins
    always_ff @(posedge mclk) begin
        if (!resetn) done_reg <= 1'b0;
        else if (finishing) done_reg <= 1'b1;
        else if (state_reg == CAL_IDLE && bus.start) done_reg <= 1'b0;
    end

    // host write takes priority over the sequencer, which only runs if started
    always_ff @(posedge mclk) begin
        if (bus.hostWr) coefMem[bus.hostIdx] <= bus.hostData;
        else if (storeStep) coefMem[stepIdx] <= bus.measure;
    end

    // stored values feed conversion until replaced
    always_ff @(posedge mclk) begin
        if (!resetn) convData_reg <= '0;
        else convData_reg <= coefMem[bus.convIdx];
    end

    assign bus.rdData = coefMem[bus.hostIdx];
    assign bus.done = done_reg;
    assign bus.convData = convData_reg;

endmodule // cal_core

// [logic/cal_core_if.sv]
`timescale 1ns/1ps
interface cal_core_if;
    import dac_cal_pkg::*;
    logic tick;
    logic start;
    logic [COEF_W-1:0] measure;
    logic hostWr;
    logic [COEF_IDX_W-1:0] hostIdx;
    logic [COEF_W-1:0] hostData;
    logic [COEF_IDX_W-1:0] convIdx;
    logic [COEF_W-1:0] rdData;
    logic [COEF_W-1:0] convData;
    logic done;

    modport core (
        input tick, start, measure, hostWr, hostIdx, hostData, convIdx,
        output rdData, convData, done
    );
    modport ctrl (
        output tick, start, measure, hostWr, hostIdx, hostData, convIdx,
        input rdData, convData, done
    );
endinterface

// [logic/dac_cal_pkg.sv]
package dac_cal_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [4:0] OFS_I_FINE_GAIN = 5'h03;
    localparam logic [4:0] OFS_I_COARSE_GAIN = 5'h04;
    localparam logic [4:0] OFS_I_CM_RESISTOR = 5'h05;
    localparam logic [4:0] OFS_Q_FINE_GAIN = 5'h06;
    localparam logic [4:0] OFS_Q_COARSE_GAIN = 5'h07;
    localparam logic [4:0] OFS_Q_CM_RESISTOR = 5'h08;
    localparam logic [4:0] OFS_REFERENCE_TRIM = 5'h0D;
    localparam logic [4:0] OFS_CAL_SETUP = 5'h0E;
    localparam logic [4:0] OFS_CAL_STATUS = 5'h0F;
    localparam logic [4:0] OFS_COEF_ADDRESS = 5'h10;
    localparam logic [4:0] OFS_COEF_DATA = 5'h11;
    localparam logic [4:0] OFS_CAL_CONTROL = 5'h12;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int SETUP_DIV_LSB = 0;
    localparam int SETUP_CLK_EN_BIT = 3;
    localparam int SETUP_I_SEL_BIT = 4;
    localparam int SETUP_Q_SEL_BIT = 5;
    localparam int STATUS_I_DONE_BIT = 6;
    localparam int STATUS_Q_DONE_BIT = 7;
    localparam int CTRL_Q_UNCAL_BIT = 0;
    localparam int CTRL_I_UNCAL_BIT = 1;
    localparam int CTRL_RD_STROBE_BIT = 2;
    localparam int CTRL_WR_STROBE_BIT = 3;
    localparam int CTRL_START_BIT = 4;
    localparam int CM_ENABLE_BIT = 7;
    localparam int SPI_READ_BIT = 7;

    // ------------------------------------------------------------
    // sizes, reset values and timing counts
    // ------------------------------------------------------------
    localparam int CODE_W = 6;
    localparam int COEF_W = 6;
    localparam int COEF_COUNT = 32;
    localparam int COEF_IDX_W = 5;
    localparam logic [7:0] COEF_ADDR_FIRST = 8'h01;
    localparam logic [7:0] COEF_ADDR_LAST = 8'h20;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam int CAL_TICKS = 300;
    localparam int CAL_PREDIV = 16;
    localparam int DIV_CNT_W = 11;
    localparam logic [2:0] DIV_SEL_MAX = 3'h6;

    typedef enum logic [1:0] {
        CAL_IDLE = 2'b00,
        CAL_RUN = 2'b01,
        CAL_FINISH = 2'b11
    } cal_state_t;

endpackage

// [logic/dac_selfcal_gain_trim_control.sv]
// Contract
// - status bits 6 and 7 show core done
// - thirty-two coefficients, readable and writable
// - writing 0x04 sets read strobe
// - data register returns six-bit coefficient
// - writing 0x08 sets write strobe
// - data write stores at addressed entry
// - reference trim six-bit two's complement
// - per-core coarse gain two's complement
// - per-core fine gain straight binary
// - common-mode resistor off at reset
// - start bit begins calibration, about 300 ticks
// - cal clock is sample clock over 16*factor
// - separate calibration hardware per core
// - writing zero clears uncalibrated-mode bits
`timescale 1ns/1ps
module dac_selfcal_gain_trim_control
    import dac_cal_pkg::*;
#(
    parameter int CAL_TICKS_P = CAL_TICKS
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic spiSclk,
    input wire logic spiCsN,
    input wire logic spiSdi,
    output logic spiSdo,
    output logic spiSdoOeN,
    input wire logic [COEF_W-1:0] iCalMeasure,
    input wire logic [COEF_W-1:0] qCalMeasure,
    input wire logic [COEF_IDX_W-1:0] convCoefIndex,
    output logic [COEF_W-1:0] iConvCoef,
    output logic [COEF_W-1:0] qConvCoef,
    output logic [CODE_W-1:0] iFineGainCode,
    output logic [CODE_W-1:0] qFineGainCode,
    output logic [CODE_W-1:0] iCoarseGainCode,
    output logic [CODE_W-1:0] qCoarseGainCode,
    output logic [CODE_W-1:0] iCmResistorCode,
    output logic [CODE_W-1:0] qCmResistorCode,
    output logic iCmResistorEnable,
    output logic qCmResistorEnable,
    output logic [CODE_W-1:0] referenceTrimCode,
    output logic iUncalMode,
    output logic qUncalMode
);

    // ------------------------------------------------------------
    // serial control port
    // ------------------------------------------------------------
    // pins are taken as synchronous to mclk, so sclk needs no synchroniser;
    // the sclk period must span several mclk cycles for edge detection
    logic sclkPrev_reg;
    logic [4:0] bitCnt_reg;
    logic [7:0] shiftIn_reg;
    logic [7:0] instr_reg;
    logic [7:0] shiftOut_reg;
    logic sdo_reg;
    logic sdoOeN_reg;

    wire logic sclkRise = spiSclk && !sclkPrev_reg;
    wire logic sclkFall = !spiSclk && sclkPrev_reg;
    wire logic [7:0] shiftedIn = {shiftIn_reg[6:0], spiSdi};
    wire logic isRead = instr_reg[SPI_READ_BIT];
    wire logic [4:0] regAddr = instr_reg[4:0];
    wire logic regWrite = !spiCsN && sclkRise && (bitCnt_reg == 5'h0F) && !isRead;
    wire logic [7:0] wrData = shiftedIn;
    logic [7:0] rdMux;

    // instruction byte then one data byte, msb first, mode 0
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            sclkPrev_reg <= 1'b0;
            bitCnt_reg <= '0;
            shiftIn_reg <= '0;
            instr_reg <= '0;
        end else begin
            sclkPrev_reg <= spiSclk;
            if (spiCsN) begin
                bitCnt_reg <= '0;
            end else if (sclkRise) begin
                shiftIn_reg <= shiftedIn;
                if (bitCnt_reg != 5'h10) bitCnt_reg <= bitCnt_reg + 5'h01;
                if (bitCnt_reg == 5'h07) instr_reg <= shiftedIn;
            end
        end
    end

    // read data is captured on the falling edge after the instruction byte
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            shiftOut_reg <= '0;
            sdo_reg <= 1'b0;
            sdoOeN_reg <= 1'b1;
        end else if (spiCsN) begin
            sdoOeN_reg <= 1'b1;
        end else if (sclkFall && isRead) begin
            if (bitCnt_reg == 5'h08) begin
                shiftOut_reg <= {rdMux[6:0], 1'b0};
                sdo_reg <= rdMux[7];
                sdoOeN_reg <= 1'b0;
            end else if (bitCnt_reg > 5'h08 && bitCnt_reg < 5'h10) begin
                shiftOut_reg <= {shiftOut_reg[6:0], 1'b0};
                sdo_reg <= shiftOut_reg[7];
            end
        end
    end

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    logic [7:0] iFine_reg, qFine_reg, iCoarse_reg, qCoarse_reg;
    logic [7:0] iCm_reg, qCm_reg, refTrim_reg, setup_reg;
    logic [7:0] coefAddr_reg, coefData_reg, control_reg;

    wire logic wrIFine = regWrite && (regAddr == OFS_I_FINE_GAIN);
    wire logic wrICoarse = regWrite && (regAddr == OFS_I_COARSE_GAIN);
    wire logic wrICm = regWrite && (regAddr == OFS_I_CM_RESISTOR);
    wire logic wrQFine = regWrite && (regAddr == OFS_Q_FINE_GAIN);
    wire logic wrQCoarse = regWrite && (regAddr == OFS_Q_COARSE_GAIN);
    wire logic wrQCm = regWrite && (regAddr == OFS_Q_CM_RESISTOR);
    wire logic wrRefTrim = regWrite && (regAddr == OFS_REFERENCE_TRIM);
    wire logic wrSetup = regWrite && (regAddr == OFS_CAL_SETUP);
    wire logic wrCoefAddr = regWrite && (regAddr == OFS_COEF_ADDRESS);
    wire logic wrCoefData = regWrite && (regAddr == OFS_COEF_DATA);
    wire logic wrControl = regWrite && (regAddr == OFS_CAL_CONTROL);

    // plain storage; the cm enable bit sits at 7 so codes stay in 5:0
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            iFine_reg <= REG_RESET;
            qFine_reg <= REG_RESET;
            iCoarse_reg <= REG_RESET;
            qCoarse_reg <= REG_RESET;
            iCm_reg <= REG_RESET;
            qCm_reg <= REG_RESET;
            refTrim_reg <= REG_RESET;
        end else begin
            if (wrIFine) iFine_reg <= wrData;
            if (wrQFine) qFine_reg <= wrData;
            if (wrICoarse) iCoarse_reg <= wrData;
            if (wrQCoarse) qCoarse_reg <= wrData;
            if (wrICm) iCm_reg <= wrData;
            if (wrQCm) qCm_reg <= wrData;
            if (wrRefTrim) refTrim_reg <= wrData;
        end
    end

    // calibration control; a zero write drops strobes, start and uncal bits
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            setup_reg <= REG_RESET;
            coefAddr_reg <= REG_RESET;
            coefData_reg <= REG_RESET;
            control_reg <= REG_RESET;
        end else begin
            if (wrSetup) setup_reg <= wrData;
            if (wrCoefAddr) coefAddr_reg <= wrData;
            if (wrCoefData) coefData_reg <= wrData;
            if (wrControl) control_reg <= wrData;
        end
    end

    // ------------------------------------------------------------
    // calibration clock and per-core engines
    // ------------------------------------------------------------
    logic [DIV_CNT_W-1:0] divCnt_reg;
    wire logic calClkEn = setup_reg[SETUP_CLK_EN_BIT];
    wire logic [2:0] cal_clock_divider = setup_reg[SETUP_DIV_LSB +: 3];
    wire logic [2:0] divSelClamped = (cal_clock_divider > DIV_SEL_MAX) ? DIV_SEL_MAX : cal_clock_divider;
    // period = 16 * 2^(sel+1): 32 .. 2048 sample clocks
    wire logic [DIV_CNT_W:0] divPeriod = (DIV_CNT_W + 1)'(CAL_PREDIV) << (divSelClamped + 3'h1);
    wire logic [DIV_CNT_W-1:0] divLast = DIV_CNT_W'(divPeriod - 12'h001);
    wire logic calTick = calClkEn && (divCnt_reg == divLast);

    // restarting from zero whenever the clock is off keeps the first tick full
    always_ff @(posedge mclk) begin
        if (!resetn) divCnt_reg <= '0;
        else if (!calClkEn || calTick) divCnt_reg <= '0;
        else divCnt_reg <= divCnt_reg + 11'h001;
    end

    wire logic iSel = setup_reg[SETUP_I_SEL_BIT];
    wire logic qSel = setup_reg[SETUP_Q_SEL_BIT];
    wire logic startReq = control_reg[CTRL_START_BIT] && calClkEn;
    wire logic addrValid = (coefAddr_reg >= COEF_ADDR_FIRST) && (coefAddr_reg <= COEF_ADDR_LAST);
    wire logic [7:0] addrLess1 = coefAddr_reg - 8'h01;
    wire logic [COEF_IDX_W-1:0] coefIdx = addrLess1[COEF_IDX_W-1:0];
    wire logic hostWrOk = wrCoefData && control_reg[CTRL_WR_STROBE_BIT] && addrValid;

    cal_core_if iBus();
    cal_core_if qBus();

    assign iBus.tick = calTick;
    assign iBus.start = startReq && iSel;
    assign iBus.measure = iCalMeasure;
    assign iBus.hostWr = hostWrOk && iSel;
    assign iBus.hostIdx = coefIdx;
    assign iBus.hostData = wrData[COEF_W-1:0];
    assign iBus.convIdx = convCoefIndex;

    assign qBus.tick = calTick;
    assign qBus.start = startReq && qSel;
    assign qBus.measure = qCalMeasure;
    assign qBus.hostWr = hostWrOk && qSel;
    assign qBus.hostIdx = coefIdx;
    assign qBus.hostData = wrData[COEF_W-1:0];
    assign qBus.convIdx = convCoefIndex;

    // separate engines so both cores can calibrate at once
    cal_core #(.CAL_TICKS_P(CAL_TICKS_P)) iCore (
        .mclk(mclk),
        .resetn(resetn),
        .bus(iBus.core)
    );
    cal_core #(.CAL_TICKS_P(CAL_TICKS_P)) qCore (
        .mclk(mclk),
        .resetn(resetn),
        .bus(qBus.core)
    );

    // ------------------------------------------------------------
    // read decode
    // ------------------------------------------------------------
    // with both cores or none selected there is no defined coefficient,
    // so the data register falls back to its last written value
    wire logic oneSel = iSel ^ qSel;
    wire logic coefRdOk = control_reg[CTRL_RD_STROBE_BIT] && oneSel && addrValid;
    wire logic [COEF_W-1:0] selCoef = iSel ? iBus.rdData : qBus.rdData;
    wire logic [7:0] coefDataView = coefRdOk ? {2'b00, selCoef} : coefData_reg;
    wire logic [7:0] statusView = {qBus.done, iBus.done, 6'b000000};

    always_comb begin
        if (regAddr == OFS_I_FINE_GAIN) rdMux = iFine_reg;
        else if (regAddr == OFS_I_COARSE_GAIN) rdMux = iCoarse_reg;
        else if (regAddr == OFS_I_CM_RESISTOR) rdMux = iCm_reg;
        else if (regAddr == OFS_Q_FINE_GAIN) rdMux = qFine_reg;
        else if (regAddr == OFS_Q_COARSE_GAIN) rdMux = qCoarse_reg;
        else if (regAddr == OFS_Q_CM_RESISTOR) rdMux = qCm_reg;
        else if (regAddr == OFS_REFERENCE_TRIM) rdMux = refTrim_reg;
        else if (regAddr == OFS_CAL_SETUP) rdMux = setup_reg;
        else if (regAddr == OFS_CAL_STATUS) rdMux = statusView;
        else if (regAddr == OFS_COEF_ADDRESS) rdMux = coefAddr_reg;
        else if (regAddr == OFS_COEF_DATA) rdMux = coefDataView;
        else if (regAddr == OFS_CAL_CONTROL) rdMux = control_reg;
        else rdMux = 8'h00;
    end

    // ------------------------------------------------------------
    // analog control outputs
    // ------------------------------------------------------------
    // codes are passed raw; format is interpreted by the analog networks
    assign iFineGainCode = iFine_reg[CODE_W-1:0];
    assign qFineGainCode = qFine_reg[CODE_W-1:0];
    assign iCoarseGainCode = iCoarse_reg[CODE_W-1:0];
    assign qCoarseGainCode = qCoarse_reg[CODE_W-1:0];
    assign iCmResistorCode = iCm_reg[CODE_W-1:0];
    assign qCmResistorCode = qCm_reg[CODE_W-1:0];
    assign iCmResistorEnable = iCm_reg[CM_ENABLE_BIT];
    assign qCmResistorEnable = qCm_reg[CM_ENABLE_BIT];
    assign referenceTrimCode = refTrim_reg[CODE_W-1:0];
    assign iUncalMode = control_reg[CTRL_I_UNCAL_BIT];
    assign qUncalMode = control_reg[CTRL_Q_UNCAL_BIT];
    assign iConvCoef = iBus.convData;
    assign qConvCoef = qBus.convData;
    assign spiSdo = sdo_reg;
    assign spiSdoOeN = sdoOeN_reg;

endmodule // dac_selfcal_gain_trim_control
